// >>> verilog/nhc_consts.vh
// constants for the nand host command controller
// Behaviour
// - fail bit trusted only when ready
// - during init only reset or status read
// - never issue unknown command codes
// - while busy only status reads or reset
// - after serial input only 85,10,11,ff
// - program pages ascending within a block
`ifndef NHC_CONSTS_VH
`define NHC_CONSTS_VH
// apb register byte offsets
`define NHC_OFF_CTRL 12'h000
`define NHC_OFF_CMD 12'h004
`define NHC_OFF_STAT 12'h008
`define NHC_OFF_IRQ 12'h00c
`define NHC_OFF_MASK 12'h010
`define NHC_OFF_DSTAT 12'h014
`define NHC_OFF_ECC 12'h018
// ctrl fields
`define NHC_CTRL_WPN 0
`define NHC_CTRL_CE 1
`define NHC_CTRL_RST 2'h0
// cmd register fields
`define NHC_CMD_KIND_HI 9
`define NHC_CMD_KIND_LO 8
`define NHC_KIND_CMD 2'h0
`define NHC_KIND_ADDR 2'h1
`define NHC_KIND_WR 2'h2
`define NHC_KIND_RD 2'h3
// irq bits
`define NHC_IRQ_DONE 0
`define NHC_IRQ_REFUSE 1
`define NHC_IRQ_READY 2
// status byte fields
`define NHC_SB_FAIL 0
`define NHC_SB_REWRITE 3
`define NHC_SB_READY 6
`define NHC_SB_UNPROT 7
// ecc byte
`define NHC_ECC_UNCORR 4'hf
`define NHC_ECC_MAXCNT 4'h8
`define NHC_ECC_MAXSEC 4'h7
// command codes
`define NHC_OP_READ 8'h00
`define NHC_OP_READ_GO 8'h30
`define NHC_OP_COPY_RD 8'h35
`define NHC_OP_STATUS 8'h70
`define NHC_OP_MSTATUS 8'h71
`define NHC_OP_ECCSTAT 8'h7a
`define NHC_OP_SERIAL 8'h80
`define NHC_OP_MSERIAL 8'h81
`define NHC_OP_COLCHG 8'h85
`define NHC_OP_PROG 8'h10
`define NHC_OP_MPROG 8'h11
`define NHC_OP_ERASE 8'h60
`define NHC_OP_ERASE_GO 8'hd0
`define NHC_OP_ID 8'h90
`define NHC_OP_RESET 8'hff
// page field in third address byte
`define NHC_PAGE_ADDR_IDX 3'h2
`define NHC_PAGE_W 6
// timing
`define NHC_CLK_NS 20
`define NHC_T_PULSE_NS 40
`define NHC_PULSE_CYC ((`NHC_T_PULSE_NS+`NHC_CLK_NS-1)/`NHC_CLK_NS)
`define NHC_SYNC_CYC 2
`endif

// >>> verilog/nhc_cycle.v
// one command, address or data cycle on the nand pins
`include "nhc_consts.vh"
module nhc_cycle (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [1:0] kind,
  input wire [7:0] din,
  input wire [7:0] io_in_s,
  output wire busy,
  output reg done,
  output reg [7:0] dout,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg re_n,
  output reg [7:0] io_out,
  output reg io_oe_n
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOW = 3'b010;
  localparam [2:0] ST_HIGH = 3'b100;
  localparam integer LOW_I = `NHC_PULSE_CYC;
  localparam integer RD_I = `NHC_PULSE_CYC + `NHC_SYNC_CYC;
  localparam [3:0] LOW_CYC = LOW_I[3:0];
  localparam [3:0] RD_CYC = RD_I[3:0];
  reg [2:0] st_r;
  reg [3:0] cnt_r;
  reg rd_r;

  assign busy = ~st_r[0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      done <= 1'b0;
      dout <= 8'h00;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe_n <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (start)
          begin
            rd_r <= (kind == `NHC_KIND_RD);
            cle <= (kind == `NHC_KIND_CMD);
            ale <= (kind == `NHC_KIND_ADDR);
            io_out <= din;
            io_oe_n <= (kind == `NHC_KIND_RD);
            we_n <= (kind == `NHC_KIND_RD);
            re_n <= (kind != `NHC_KIND_RD);
            // read low phase covers the input synchroniser delay
            cnt_r <= (kind == `NHC_KIND_RD) ? RD_CYC - 4'h1 : LOW_CYC - 4'h1;
            st_r <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          if (cnt_r == 4'h0)
          begin
            we_n <= 1'b1;
            re_n <= 1'b1;
            if (rd_r)
              dout <= io_in_s;
            cnt_r <= LOW_CYC - 4'h1;
            st_r <= ST_HIGH;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        ST_HIGH:
        begin
          if (cnt_r == 4'h0)
          begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe_n <= 1'b1;
            done <= 1'b1;
            st_r <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // nhc_cycle

// >>> verilog/nhc_host.v
// apb-controlled nand host: command checks, status and ecc capture
//
// Design decisions made here: the APB slave port and the register addresses.
`include "nhc_consts.vh"
module nhc_host (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  output reg nand_ce_n,
  output wire nand_cle,
  output wire nand_ale,
  output wire nand_we_n,
  output wire read_strobe_n,
  output reg nand_wp_n,
  output wire [7:0] io_out,
  output wire io_oe_n,
  input wire [7:0] io_in,
  input wire ready_busy_out
);
  // ==========================================================
  // functions
  function known_op;
    input [7:0] op;
    begin
      case (op)
        `NHC_OP_READ, `NHC_OP_READ_GO, `NHC_OP_COPY_RD, `NHC_OP_STATUS,
        `NHC_OP_MSTATUS, `NHC_OP_ECCSTAT, `NHC_OP_SERIAL,
        `NHC_OP_MSERIAL, `NHC_OP_COLCHG, `NHC_OP_PROG, `NHC_OP_MPROG,
        `NHC_OP_ERASE, `NHC_OP_ERASE_GO, `NHC_OP_ID, `NHC_OP_RESET:
          known_op = 1'b1;
        default:
          known_op = 1'b0;
      endcase
    end
  endfunction

  function is_status_op;
    input [7:0] op;
    begin
      is_status_op = (op == `NHC_OP_STATUS) || (op == `NHC_OP_MSTATUS);
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg rb_s1_r;
  reg rb_s2_r;
  reg [7:0] io_s1_r;
  reg [7:0] io_s2_r;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
    end
    else
    begin
      rb_s1_r <= ready_busy_out;
      rb_s2_r <= rb_s1_r;
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // ==========================================================
  // register state
  reg [1:0] ctrl_r;
  reg [2:0] irq_st_r;
  reg [2:0] irq_st_nxt;
  reg [2:0] mask_r;
  reg init_done_r;
  reg rdy_d_r;
  reg prog_pend_r;
  reg status_mode_r;
  reg [7:0] last_op_r;
  reg [2:0] addr_idx_r;
  reg [5:0] page_r;
  reg [5:0] next_page_r;
  reg [7:0] rd_byte_r;
  reg [7:0] dstat_r;
  reg fail_valid_r;
  reg [7:0] ecc_r;
  reg [1:0] pend_kind_r;

  wire eng_busy;
  wire eng_done;
  wire [7:0] eng_dout;
  reg eng_start;
  reg refuse;

  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire cmd_wr = wr_acc && (paddr == `NHC_OFF_CMD);
  wire [1:0] kind = pwdata[`NHC_CMD_KIND_HI:`NHC_CMD_KIND_LO];
  wire [7:0] wbyte = pwdata[7:0];
  wire rdy_s = rb_s2_r;

  // ==========================================================
  // command legality
  always @*
  begin
    refuse = 1'b0;
    if (eng_busy)
      refuse = 1'b1;
    else if (kind == `NHC_KIND_CMD)
    begin
      if (!known_op(wbyte))
        refuse = 1'b1;
      else if (!init_done_r && !(wbyte == `NHC_OP_RESET ||
               wbyte == `NHC_OP_STATUS))
        refuse = 1'b1;
      else if (!rdy_s && !(is_status_op(wbyte) ||
               wbyte == `NHC_OP_RESET))
        refuse = 1'b1;
      else if (prog_pend_r && !(wbyte == `NHC_OP_COLCHG ||
               wbyte == `NHC_OP_PROG || wbyte == `NHC_OP_MPROG ||
               wbyte == `NHC_OP_RESET))
        refuse = 1'b1;
      else if ((wbyte == `NHC_OP_PROG || wbyte == `NHC_OP_MPROG) &&
               page_r != 6'h00 && page_r != next_page_r)
        refuse = 1'b1;
    end
    else if (kind == `NHC_KIND_WR && !ctrl_r[`NHC_CTRL_WPN] &&
             prog_pend_r)
      refuse = 1'b1;
    eng_start = cmd_wr & ~refuse;
  end

  nhc_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(eng_start),
    .kind(kind),
    .din(wbyte),
    .io_in_s(io_s2_r),
    .busy(eng_busy),
    .done(eng_done),
    .dout(eng_dout),
    .cle(nand_cle),
    .ale(nand_ale),
    .we_n(nand_we_n),
    .re_n(read_strobe_n),
    .io_out(io_out),
    .io_oe_n(io_oe_n)
  );

  // ==========================================================
  // sticky interrupt status: events win over read-clear
  always @*
  begin
    irq_st_nxt = irq_st_r;
    if (rd_acc && paddr == `NHC_OFF_IRQ)
      irq_st_nxt = 3'h0;
    irq_st_nxt[`NHC_IRQ_DONE] = irq_st_nxt[`NHC_IRQ_DONE] | eng_done;
    irq_st_nxt[`NHC_IRQ_REFUSE] = irq_st_nxt[`NHC_IRQ_REFUSE] |
                                  (cmd_wr & refuse);
    irq_st_nxt[`NHC_IRQ_READY] = irq_st_nxt[`NHC_IRQ_READY] |
                                 (rdy_s & ~rdy_d_r);
  end

  // ==========================================================
  // controller state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `NHC_CTRL_RST;
      irq_st_r <= 3'h0;
      mask_r <= 3'h0;
      irq <= 1'b0;
      nand_ce_n <= 1'b1;
      nand_wp_n <= 1'b0;
      init_done_r <= 1'b0;
      rdy_d_r <= 1'b0;
      prog_pend_r <= 1'b0;
      status_mode_r <= 1'b0;
      last_op_r <= 8'h00;
      addr_idx_r <= 3'h0;
      page_r <= 6'h00;
      next_page_r <= 6'h00;
      rd_byte_r <= 8'h00;
      dstat_r <= 8'h00;
      fail_valid_r <= 1'b0;
      ecc_r <= 8'h00;
      pend_kind_r <= 2'h0;
    end
    else
    begin
      irq_st_r <= irq_st_nxt;
      irq <= |(irq_st_nxt & mask_r);
      rdy_d_r <= rdy_s;
      nand_ce_n <= ~ctrl_r[`NHC_CTRL_CE];
      nand_wp_n <= ctrl_r[`NHC_CTRL_WPN];
      if (rdy_s)
        init_done_r <= 1'b1;
      if (wr_acc && paddr == `NHC_OFF_CTRL)
        ctrl_r <= pwdata[1:0];
      if (wr_acc && paddr == `NHC_OFF_MASK)
        mask_r <= pwdata[2:0];
      if (eng_start)
      begin
        pend_kind_r <= kind;
        if (kind == `NHC_KIND_CMD)
        begin
          last_op_r <= wbyte;
          case (wbyte)
            `NHC_OP_SERIAL, `NHC_OP_MSERIAL:
            begin
              prog_pend_r <= 1'b1;
              addr_idx_r <= 3'h0;
            end
            `NHC_OP_PROG, `NHC_OP_MPROG:
            begin
              prog_pend_r <= 1'b0;
              next_page_r <= page_r + 6'h01;
            end
            `NHC_OP_STATUS:
              status_mode_r <= 1'b1;
            `NHC_OP_READ:
              status_mode_r <= 1'b0;
            `NHC_OP_RESET:
            begin
              prog_pend_r <= 1'b0;
              status_mode_r <= 1'b0;
            end
            default:
              status_mode_r <= status_mode_r;
          endcase
        end
        else if (kind == `NHC_KIND_ADDR && prog_pend_r)
        begin
          if (addr_idx_r == `NHC_PAGE_ADDR_IDX)
            page_r <= wbyte[`NHC_PAGE_W-1:0];
          addr_idx_r <= addr_idx_r + 3'h1;
        end
      end
      // falling protect drops a pending program once
      if (nand_wp_n && !ctrl_r[`NHC_CTRL_WPN])
        prog_pend_r <= 1'b0;
      if (eng_done && pend_kind_r == `NHC_KIND_RD)
      begin
        rd_byte_r <= eng_dout;
        if (status_mode_r || is_status_op(last_op_r))
        begin
          dstat_r <= eng_dout;
          fail_valid_r <= eng_dout[`NHC_SB_READY];
        end
        if (last_op_r == `NHC_OP_ECCSTAT)
          ecc_r <= eng_dout;
      end
    end
  end

  // ==========================================================
  // apb slave: one wait state, answer on second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready)
      begin
        prdata <= 32'h00000000;
        if (paddr == `NHC_OFF_CTRL)
          prdata <= {30'h0, ctrl_r};
        else if (paddr == `NHC_OFF_CMD)
          prdata <= {24'h0, last_op_r};
        else if (paddr == `NHC_OFF_STAT)
          prdata <= {16'h0, rd_byte_r, 3'h0, prog_pend_r,
                     status_mode_r, init_done_r, rdy_s,
                     eng_busy | eng_done}; // busy covers result store
        else if (paddr == `NHC_OFF_IRQ)
          prdata <= {29'h0, irq_st_r};
        else if (paddr == `NHC_OFF_MASK)
          prdata <= {29'h0, mask_r};
        else if (paddr == `NHC_OFF_DSTAT)
          prdata <= {23'h0, fail_valid_r, dstat_r};
        else if (paddr == `NHC_OFF_ECC)
          prdata <= {24'h0, ecc_r};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule // nhc_host

// >>> testbench/nhc_host_properties.sv
// assertion checker for the nand host controller
module nhc_host_props (
  input wire pclk,
  input wire presetn,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire nand_cle,
  input wire nand_ale,
  input wire nand_we_n,
  input wire nand_wp_n,
  input wire [7:0] io_out,
  input wire ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // pin event tracking
  reg we_d_r;
  reg seen_r;
  reg pend_r;
  reg [2:0] lo_r;
  reg [1:0] na_r;
  reg [5:0] page_r;
  reg [5:0] last_r;
  wire cmd = nand_cle & we_d_r & ~nand_we_n;
  wire adr = nand_ale & we_d_r & ~nand_we_n;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      we_d_r <= 1'b1;
      seen_r <= 1'b0;
      pend_r <= 1'b0;
      lo_r <= 3'h0;
      na_r <= 2'h0;
      page_r <= 6'h00;
      last_r <= 6'h00;
    end
    else
    begin
      we_d_r <= nand_we_n;
      seen_r <= seen_r | ready_busy_out;
      lo_r <= ready_busy_out ? 3'h0 : lo_r + {2'h0, lo_r != 3'h7};
      if (cmd)
        pend_r <= io_out == 8'h80 || io_out == 8'h81 ||
          (pend_r && io_out == 8'h85);
      else if (!nand_wp_n)
        pend_r <= 1'b0;
      if (cmd && io_out[7:1] == 7'h08)
        last_r <= page_r;
      if (cmd)
        na_r <= 2'h0;
      else if (adr)
        na_r <= na_r + {1'b0, na_r != 2'h3};
      if (adr && na_r == 2'h2)
        page_r <= io_out[5:0];
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_FAIL_VALID:
  assert property (pready && !pwrite && paddr == 12'h014 |->
    prdata[8] == prdata[6]) else $error("fail valid flag wrong");
  AST_INIT_CMD:
  assert property (cmd && !seen_r |-> io_out inside {8'hff, 8'h70})
    else $error("command during init");
  AST_KNOWN_CMD:
  assert property (cmd |-> io_out inside {8'h00, 8'h30, 8'h35, 8'h70,
    8'h71, 8'h7a, 8'h80, 8'h81, 8'h85, 8'h10, 8'h11, 8'h60, 8'hd0,
    8'h90, 8'hff}) else $error("unknown command");
  AST_BUSY_CMD:
  assert property (cmd && lo_r > 3'h4 |->
    io_out inside {8'h70, 8'h71, 8'hff}) else $error("command while busy");
  AST_SERIAL_CMD:
  assert property (cmd && pend_r |->
    io_out inside {8'h85, 8'h10, 8'h11, 8'hff}) else $error("after serial");
  AST_PAGE_ORDER:
  assert property (cmd && io_out[7:1] == 7'h08 |->
    page_r == 6'h00 || page_r == last_r + 6'h01) else $error("page order");
  AST_WE_PULSE:
  assert property ($fell(nand_we_n) |-> !nand_we_n [*2] ##1 nand_we_n [*2])
    else $error("write strobe width");
endmodule // nhc_host_props

bind nhc_host nhc_host_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .nand_cle(nand_cle),
  .nand_ale(nand_ale),
  .nand_we_n(nand_we_n),
  .nand_wp_n(nand_wp_n),
  .io_out(io_out),
  .ready_busy_out(ready_busy_out)
);

// >>> testbench/nhc_dev_model.sv
// behavioural nand device facing the host controller pins
module nhc_dev_model #(
  parameter int INIT_TK = 60,
  parameter int BUSY_TK = 120,
  parameter logic [7:0] ECC_BYTE = 8'h23
) (
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire re_n,
  input wire wp_n,
  input wire [7:0] din,
  output wire [7:0] dout,
  output wire rb
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // device state
  int busy_left = INIT_TK;
  logic stat_m = 1'b0;
  logic ecc_m = 1'b0;
  logic ser = 1'b0;
  logic pend = 1'b0;
  logic prog = 1'b0;
  logic first = 1'b0;
  logic [7:0] col = 8'h00;
  logic [7:0] last_out = 8'h00;
  wire [7:0] sts = {wp_n, rb, rb, 5'h00};
  wire [7:0] cur = ecc_m ? ECC_BYTE : (stat_m ? sts : col);
  assign rb = busy_left == 0;
  // released bus shows the inverse of the last byte
  assign dout = (!re_n && !ce_n) ? cur : ~last_out;
  always #20
    if (busy_left > 0)
      busy_left--;
  always @(negedge wp_n)
    if (prog && busy_left > 0)
      busy_left = 2;
  always @(posedge we_n)
  begin
    if (!ce_n && cle)
    begin
      pend = ser;
      ser = 1'b0;
      first = 1'b1;
      ecc_m = 1'b0;
      if (din == 8'h00 || din == 8'hff)
        stat_m = 1'b0;
      case (din)
        8'hff: busy_left = 3;
        8'h70: stat_m = 1'b1;
        8'h7a: ecc_m = 1'b1;
        8'h30: busy_left = BUSY_TK;
        8'h80: ser = 1'b1;
        8'h85: ser = pend;
        8'h10: prog = wp_n && pend;
        default: ;
      endcase
      if (prog && din == 8'h10)
        busy_left = BUSY_TK;
    end
    else if (!ce_n && ale)
    begin
      if (first)
        col = din;
      first = 1'b0;
    end
  end
  always @(posedge re_n)
  begin
    last_out = cur;
    if (!stat_m && !ecc_m)
      col++;
  end
endmodule // nhc_dev_model

// >>> testbench/tb.sv
// self-checking bench for the nand host controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // clock, bus and pins
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rd;
  logic err;
  logic [7:0] st;
  int miscompares = 0;
  int checks_done = 0;
  wire [31:0] prdata;
  wire [7:0] io_o, io_i, dev_o;
  wire pready, pslverr, irq, ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb;
  assign io_i = oe_n ? dev_o : io_o;
  always #10 pclk = ~pclk;
  nhc_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .read_strobe_n(re_n), .nand_wp_n(wp_n), .io_out(io_o),
    .io_oe_n(oe_n), .io_in(io_i), .ready_busy_out(rb));
  nhc_dev_model u_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .din(io_o), .dout(dev_o), .rb(rb));
  // ==========
  // tasks
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, 12'h008, 0);
      n++;
    end
    while (rd[b] !== v && n < 200);
    chk("stat", {31'h0, v}, {31'h0, rd[b]});
  endtask
  task automatic op(input logic [9:0] c, input logic [1:0] ei);
    xfer(1'b1, 12'h004, {22'h0, c});
    poll(0, 1'b0);
    st = rd[15:8];
    xfer(1'b0, 12'h00c, 0);
    chk("irq", {30'h0, ei}, {30'h0, rd[1:0]});
  endtask
  task automatic rd_byte(input logic [7:0] e);
    op(10'h300, 2'b01);
    chk("byte", {24'h0, e}, {24'h0, st});
  endtask
  task automatic note(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // tests
  initial
  begin
    #400us;
    miscompares++;
    wrap_up;
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h000, 0);
    chk("ctrl", 0, rd);
    xfer(1'b0, 12'h1fc, 0);
    chk("unmapped", 1, {rd[30:0], err});
    xfer(1'b1, 12'h000, 3);
    op(10'h000, 2'b10);
    op(10'h070, 2'b01);
    rd_byte(8'h80);
    xfer(1'b0, 12'h014, 0);
    chk("dstat", 32'h080, rd);
    poll(1, 1'b1);
    rd_byte(8'he0);
    xfer(1'b0, 12'h014, 0);
    chk("dstat", 32'h1e0, rd);
    op(10'h055, 2'b10);
    note("init");
    op(10'h000, 2'b01);
    for (int i = 0; i < 5; i++)
      op(i == 0 ? 10'h112 : 10'h100, 2'b01);
    op(10'h030, 2'b01);
    op(10'h000, 2'b10);
    op(10'h070, 2'b01);
    rd_byte(8'h80);
    poll(1, 1'b1);
    rd_byte(8'he0);
    op(10'h000, 2'b01);
    rd_byte(8'h12);
    rd_byte(8'h13);
    op(10'h07a, 2'b01);
    rd_byte(8'h23);
    xfer(1'b0, 12'h018, 0);
    chk("ecc", 32'h023, rd);
    note("read");
    op(10'h080, 2'b01);
    for (int i = 0; i < 5; i++)
      op(10'h100, 2'b01);
    op(10'h2a5, 2'b01);
    op(10'h000, 2'b10);
    op(10'h010, 2'b01);
    poll(1, 1'b1);
    op(10'h070, 2'b01);
    rd_byte(8'he0);
    op(10'h080, 2'b01);
    for (int i = 0; i < 5; i++)
      op(i == 2 ? 10'h105 : 10'h100, 2'b01);
    op(10'h010, 2'b10);
    op(10'h0ff, 2'b01);
    op(10'h0ff, 2'b01);
    poll(1, 1'b1);
    note("program");
    op(10'h080, 2'b01);
    xfer(1'b1, 12'h000, 2);
    xfer(1'b0, 12'h008, 0);
    chk("drop", 0, {31'h0, rd[4]});
    op(10'h070, 2'b01);
    rd_byte(8'h60);
    op(10'h080, 2'b01);
    op(10'h2a5, 2'b10);
    op(10'h0ff, 2'b01);
    xfer(1'b1, 12'h000, 3);
    note("protect");
    for (int m = 1; m >= 0; m--)
    begin
      xfer(1'b1, 12'h010, m);
      xfer(1'b1, 12'h004, 32'h070);
      repeat (12) @(posedge pclk);
      chk("irq pin", m, {31'h0, irq});
      xfer(1'b0, 12'h00c, 0);
      chk("irq done", 1, {31'h0, rd[0]});
    end
    repeat (2) @(posedge pclk);
    chk("irq clear", 0, {31'h0, irq});
    note("irq");
    wrap_up;
  end
endmodule // tb
